// File: design/nv_byte_access_ctrl.sv
module nv_byte_access_ctrl
    import nv_access_pkg::*;
#(
    parameter int PROG_CYC  = PROG_CYCLES,
    parameter int FETCH_CYC = FETCH_CYCLES
) (
    // clock and reset
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    // data-memory register port
    input  wire logic [7:0] sector_i,
    input  wire logic [7:0] offset_i,
    input  wire logic       wr_i,
    input  wire logic [7:0] wdata_i,
    output logic      [7:0] rdata_o,
    // status
    output logic            busy_o,
    output logic            done_irq_o
);
    import nv_access_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic hit(input logic [7:0] sec, input logic [7:0] off);
        hit = (sector_i == sec) && (offset_i == off);
    endfunction

    logic             loc_hit;
    logic             val_hit;
    logic             ctrl_hit;
    logic             irq_hit;
    assign loc_hit  = hit(LOC_SECTOR, LOC_OFFSET);
    assign val_hit  = hit(VAL_SECTOR, VAL_OFFSET);
    assign ctrl_hit = hit(CTRL_SECTOR, CTRL_OFFSET);
    assign irq_hit  = hit(IRQ_SECTOR, IRQ_OFFSET);

    logic [7:0]       loc_r;
    logic [7:0]       val_r;
    logic             prog_perm_r;
    logic             prog_trig_r;
    logic             fetch_perm_r;
    logic             fetch_trig_r;
    logic             done_flag_r;
    logic             done_en_r;
    nv_state_t        state_r;
    nv_state_t        state_nxt;
    logic [31:0]      cnt_r;
    logic [NV_AW-1:0] op_addr_r;
    logic [NV_DW-1:0] op_data_r;

    nv_array_if       arr ();

    nv_store_array #(
        .DEPTH (NV_DEPTH)
    ) u_store (
        .mclk_i (mclk_i),
        .port   (arr.mem)
    );

    ////////////////////////////////////////////////////////////////////////////
    logic             ctrl_wr;
    logic             start_prog;
    logic             start_fetch;
    logic             cyc_end;
    assign ctrl_wr = wr_i && ctrl_hit;
    // trigger only counts if the permit was already set beforehand
    assign start_prog  = ctrl_wr && wdata_i[PROG_TRIG_BIT] && prog_perm_r
                         && (state_r == ST_IDLE);
    assign start_fetch = ctrl_wr && wdata_i[FETCH_TRIG_BIT] && fetch_perm_r
                         && !start_prog && (state_r == ST_IDLE);
    assign cyc_end = (state_r != ST_IDLE) && (cnt_r == 32'h0000_0000);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (start_prog) begin
                    state_nxt = ST_PROG;
                end else if (start_fetch) begin
                    state_nxt = ST_FETCH;
                end
            end
            ST_FETCH,
            ST_PROG: begin
                if (cyc_end) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // cycle timer
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            cnt_r <= 32'h0000_0000;
        end else if (start_prog) begin
            cnt_r <= 32'(PROG_CYC - 1);
        end else if (start_fetch) begin
            cnt_r <= 32'(FETCH_CYC - 1);
        end else if (cnt_r != 32'h0000_0000) begin
            cnt_r <= cnt_r - 32'h0000_0001;
        end
    end

    // snapshot so later loc/val writes cannot change the operation's address or data (clearing the program permit still cancels the write)
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            op_addr_r <= LOC_RESET;
            op_data_r <= VAL_RESET;
        end else if (start_prog || start_fetch) begin
            op_addr_r <= loc_r;
            op_data_r <= val_r;
        end
    end

    assign arr.addr  = op_addr_r;
    assign arr.wdata = op_data_r;
    assign arr.wr_en = (state_r == ST_PROG) && cyc_end && prog_perm_r;

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            loc_r <= LOC_RESET;
        end else if (wr_i && loc_hit) begin
            loc_r <= wdata_i;
        end
    end

    // read result wins over a software write in the same cycle
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            val_r <= VAL_RESET;
        end else if ((state_r == ST_FETCH) && cyc_end) begin
            val_r <= arr.rdata;
        end else if (wr_i && val_hit) begin
            val_r <= wdata_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            prog_perm_r  <= CTRL_RESET[PROG_PERM_BIT];
            fetch_perm_r <= CTRL_RESET[FETCH_PERM_BIT];
        end else if (ctrl_wr) begin
            prog_perm_r  <= wdata_i[PROG_PERM_BIT];
            fetch_perm_r <= wdata_i[FETCH_PERM_BIT];
        end
    end

    // triggers: set only by an accepted start, cleared by hardware at end
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            prog_trig_r <= CTRL_RESET[PROG_TRIG_BIT];
        end else if (start_prog) begin
            prog_trig_r <= 1'b1;
        end else if ((state_r == ST_PROG) && cyc_end) begin
            prog_trig_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            fetch_trig_r <= CTRL_RESET[FETCH_TRIG_BIT];
        end else if (start_fetch) begin
            fetch_trig_r <= 1'b1;
        end else if ((state_r == ST_FETCH) && cyc_end) begin
            fetch_trig_r <= 1'b0;
        end
    end

    // done flag: hardware set wins over a software clear
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            done_flag_r <= 1'b0;
            done_en_r   <= 1'b0;
        end else begin
            if ((state_r == ST_PROG) && cyc_end) begin
                done_flag_r <= 1'b1;
            end else if (wr_i && irq_hit) begin
                done_flag_r <= wdata_i[DONE_FLAG_BIT];
            end
            if (wr_i && irq_hit) begin
                done_en_r <= wdata_i[DONE_EN_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        rdata_o = 8'h00;
        if (loc_hit) begin
            rdata_o = loc_r;
        end else if (val_hit) begin
            rdata_o = val_r;
        end else if (ctrl_hit) begin
            rdata_o = {4'h0, prog_perm_r, prog_trig_r,
                       fetch_perm_r, fetch_trig_r};
        end else if (irq_hit) begin
            rdata_o = {6'h00, done_en_r, done_flag_r};
        end
    end

    assign busy_o     = (state_r != ST_IDLE);
    assign done_irq_o = done_flag_r && done_en_r;
endmodule

// File: design/nv_access_pkg.sv
package nv_access_pkg;

    // register map: data-memory sector and offset within the sector
    localparam logic [7:0] LOC_SECTOR      = 8'h00;
    localparam logic [7:0] LOC_OFFSET      = 8'h40;
    localparam logic [7:0] VAL_SECTOR      = 8'h00;
    localparam logic [7:0] VAL_OFFSET      = 8'h41;
    localparam logic [7:0] CTRL_SECTOR     = 8'h01;
    localparam logic [7:0] CTRL_OFFSET     = 8'h3E;
    localparam logic [7:0] IRQ_SECTOR      = 8'h00;
    localparam logic [7:0] IRQ_OFFSET      = 8'h42;

    // nv_control field positions
    localparam int         FETCH_TRIG_BIT  = 0;
    localparam int         FETCH_PERM_BIT  = 1;
    localparam int         PROG_TRIG_BIT   = 2;
    localparam int         PROG_PERM_BIT   = 3;
    // interrupt register field positions
    localparam int         DONE_FLAG_BIT   = 0;
    localparam int         DONE_EN_BIT     = 1;

    // reset values
    localparam logic [7:0] LOC_RESET       = 8'h00;
    localparam logic [7:0] VAL_RESET       = 8'h00;
    localparam logic [3:0] CTRL_RESET      = 4'h0;

    // array geometry
    localparam int         NV_DEPTH        = 256;
    localparam int         NV_AW           = 8;
    localparam int         NV_DW           = 8;

    // timing
    localparam int         CLK_PERIOD_NS   = 5;
    localparam int         PROG_TIME_US    = 2000;
    localparam int         PROG_CYCLES     = (PROG_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int         FETCH_CYCLES    = 2;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FETCH,
        ST_PROG
    } nv_state_t;

endpackage

// File: design/nv_array_if.sv
interface nv_array_if;
    import nv_access_pkg::*;
    logic                 wr_en;
    logic [NV_AW-1:0]     addr;
    logic [NV_DW-1:0]     wdata;
    logic [NV_DW-1:0]     rdata;

    modport ctrl (output wr_en, output addr, output wdata, input rdata);
    modport mem  (input wr_en, input addr, input wdata, output rdata);
endinterface

// File: design/nv_store_array.sv
module nv_store_array
    import nv_access_pkg::*;
#(
    parameter int DEPTH = NV_DEPTH
) (
    input  wire logic       mclk_i,
    nv_array_if.mem         port
);
    // not reset: contents are nonvolatile by intent
    logic [NV_DW-1:0] cells [DEPTH];
    logic [NV_DW-1:0] rdata_r;

    always_ff @(posedge mclk_i) begin
        if (port.wr_en) begin
            cells[port.addr] <= port.wdata;
        end
    end

    always_ff @(posedge mclk_i) begin
        rdata_r <= cells[port.addr];
    end

    assign port.rdata = rdata_r;
endmodule

// File: testbench/nv_byte_access_ctrl_monitor.sv
module nv_byte_access_ctrl_monitor #(
    parameter int PROG_CYC  = 20,
    parameter int FETCH_CYC = 2
) (
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    input  wire logic [7:0] sector_i,
    input  wire logic [7:0] offset_i,
    input  wire logic       wr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic [7:0] rdata_o,
    input  wire logic       busy_o,
    input  wire logic       done_irq_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic        ctl;
    logic [31:0] busy_cnt_r;
    assign ctl = sector_i == 8'h01 && offset_i == 8'h3E;
    // length of the current busy run, judged when busy drops
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i || !busy_o)
            busy_cnt_r <= '0;
        else
            busy_cnt_r <= busy_cnt_r + 1;
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////////////////////////////////////////////
    chk_upper_bits_zero: assert property (ctl |-> rdata_o[7:4] == 4'h0)
        else $error("control upper bits not zero");
    chk_reset_idle: assert property ($rose(rst_n_i) |-> !busy_o && !done_irq_o)
        else $error("not idle after reset");
    chk_no_permit_ignored: assert property (wr_i && ctl && !busy_o && !rdata_o[3]
        && !rdata_o[1] |=> !busy_o) else $error("trigger without permit started");
    chk_write_starts: assert property (wr_i && ctl && !busy_o && rdata_o[3]
        && wdata_i[3:2] == 2'h3 |=> busy_o) else $error("write did not start");
    chk_read_timing: assert property (wr_i && ctl && !busy_o && rdata_o[1] && wdata_i[1]
        && wdata_i[0] && !wdata_i[2] |=> busy_o [*2] ##1 !busy_o) else $error("read length");
    chk_cycle_length: assert property ($fell(busy_o) |-> busy_cnt_r == FETCH_CYC
        || (busy_cnt_r >= PROG_CYC && busy_cnt_r <= PROG_CYC + 2)) else $error("cycle length");
    chk_trig_cleared: assert property ($fell(busy_o) && ctl |-> rdata_o[2] == 1'b0
        && rdata_o[0] == 1'b0) else $error("trigger not cleared at end");
    chk_irq_cause: assert property ($rose(done_irq_o) |-> $past(busy_o) || $past(wr_i))
        else $error("irq without cause");
endmodule

bind nv_byte_access_ctrl nv_byte_access_ctrl_monitor #(
    .PROG_CYC (PROG_CYC),
    .FETCH_CYC(FETCH_CYC)
) i_nv_byte_access_ctrl_monitor (
    .mclk_i    (mclk_i),
    .rst_n_i   (rst_n_i),
    .sector_i  (sector_i),
    .offset_i  (offset_i),
    .wr_i      (wr_i),
    .wdata_i   (wdata_i),
    .rdata_o   (rdata_o),
    .busy_o    (busy_o),
    .done_irq_o(done_irq_o)
);

// File: testbench/sw_host.sv
module sw_host (
    input  wire logic       mclk_i,
    input  wire logic [7:0] rdata_i,
    output logic      [7:0] sector_o,
    output logic      [7:0] offset_o,
    output logic            wr_o,
    output logic      [7:0] wdata_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        sector_o = 8'h00;
        offset_o = 8'h00;
        wr_o     = 1'b0;
        wdata_o  = 8'hA5;
    end
    // data lines show the inverse once released, so stale bytes never look valid
    task automatic put(input logic [7:0] s, input logic [7:0] o, input logic [7:0] d);
        @(posedge mclk_i);
        sector_o <= s;
        offset_o <= o;
        wdata_o  <= d;
        wr_o     <= 1'b1;
        @(posedge mclk_i);
        wr_o     <= 1'b0;
        wdata_o  <= ~d;
    endtask
    task automatic get(input logic [7:0] s, input logic [7:0] o, output logic [7:0] d);
        @(posedge mclk_i);
        sector_o <= s;
        offset_o <= o;
        @(posedge mclk_i);
        d = rdata_i;
    endtask
endmodule

// File: testbench/nv_byte_access_ctrl_tb.sv
module nv_byte_access_ctrl_tb import nv_access_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int PC = 20;
    logic        mclk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [7:0]  sec, off, wd, rd, a, d;
    logic        wr, busy, irq;
    logic [31:0] seed = 32'd91108;
    int          error_cnt = 0;
    int          total_checks = 0;
    // behavioural store and the bytes that reads are expected to return
    int          mdl_mem [256];
    int          exp_q [$];
    always #2.5 mclk_i = ~mclk_i;
    nv_byte_access_ctrl #(.PROG_CYC(PC), .FETCH_CYC(2)) i_nv_byte_access_ctrl (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .sector_i(sec), .offset_i(off),
        .wr_i(wr), .wdata_i(wd), .rdata_o(rd), .busy_o(busy), .done_irq_o(irq));
    sw_host i_sw_host (.mclk_i(mclk_i), .rdata_i(rd), .sector_o(sec), .offset_o(off),
        .wr_o(wr), .wdata_o(wd));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t byte %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t irq %b expected %b", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] s, input logic [7:0] o, input logic [7:0] exp);
        logic [7:0] v;
        i_sw_host.get(s, o, v);
        chk8(v, exp);
    endtask
    // bounded poll of a trigger bit until hardware clears it
    task automatic poll(input int b);
        logic [7:0] v;
        v = 8'hFF;
        for (int n = 0; n < 4 * PC && v[b] !== 1'b0; n++)
            i_sw_host.get(8'h01, 8'h3E, v);
        chk8({7'h00, v[b]}, 8'h00);
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        #(200 * PC * 5);
        error_cnt++;
        print_verdict();
    end
    initial begin
        repeat (5) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        rdchk(8'h00, 8'h40, 8'h00);
        rdchk(8'h00, 8'h41, 8'h00);
        rdchk(8'h01, 8'h3E, 8'h00);
        rdchk(8'h00, 8'h43, 8'h00);
        i_sw_host.put(8'h01, 8'h3E, 8'h04);
        rdchk(8'h01, 8'h3E, 8'h00);
        i_sw_host.put(8'h01, 8'h3E, 8'h01);
        rdchk(8'h01, 8'h3E, 8'h00);
        i_sw_host.put(8'h01, 8'h3E, 8'hF0);
        rdchk(8'h01, 8'h3E, 8'h00);
        for (int k = 0; k < 3; k++) begin
            a = (k == 0) ? 8'hFF : rnd();
            d = rnd();
            i_sw_host.put(8'h00, 8'h40, a);
            i_sw_host.put(8'h00, 8'h41, d);
            i_sw_host.put(8'h01, 8'h3E, 8'h08);
            i_sw_host.put(8'h01, 8'h3E, 8'h0C);
            i_sw_host.put(8'h00, 8'h40, ~a);
            i_sw_host.put(8'h00, 8'h41, ~d);
            poll(2);
            mdl_mem[a] = d;
            rdchk(8'h00, 8'h41, ~d);
            rdchk(8'h00, 8'h42, 8'h01);
            i_sw_host.put(8'h00, 8'h42, 8'h03);
            // irq register updates on the edge put returns at: look once settled
            @(negedge mclk_i);
            chk1(irq, 1'b1);
            i_sw_host.put(8'h00, 8'h42, 8'h00);
            @(negedge mclk_i);
            chk1(irq, 1'b0);
            i_sw_host.put(8'h00, 8'h40, a);
            i_sw_host.put(8'h01, 8'h3E, 8'h02);
            i_sw_host.put(8'h01, 8'h3E, 8'h03);
            exp_q.push_back(mdl_mem[a]);
            poll(0);
            rdchk(8'h00, 8'h41, 8'(exp_q.pop_front()));
            rdchk(8'h01, 8'h3E, 8'h02);
            i_sw_host.put(8'h01, 8'h3E, 8'h00);
        end
        // permit withdrawn mid-cycle: the array must keep its old byte
        i_sw_host.put(8'h00, 8'h41, ~d);
        i_sw_host.put(8'h01, 8'h3E, 8'h08);
        i_sw_host.put(8'h01, 8'h3E, 8'h0C);
        i_sw_host.put(8'h01, 8'h3E, 8'h00);
        poll(2);
        i_sw_host.put(8'h01, 8'h3E, 8'h02);
        i_sw_host.put(8'h01, 8'h3E, 8'h03);
        exp_q.push_back(mdl_mem[a]);
        poll(0);
        rdchk(8'h00, 8'h41, 8'(exp_q.pop_front()));
        print_verdict();
    end
endmodule
